// >>> rtc_pwr_pkg.sv
// package: register map, field layout, reset values and timing for the power and wake control block
package rtc_pwr_pkg;
  // register byte address and bus constants
  localparam logic [31:0] ADDR_POWER_WAKE_CONTROL = 32'h0000_1930;
  localparam logic [31:0] ADDR_STATUS             = 32'h0000_1934;
  localparam int          REG_WIDTH               = 16;
  // control field positions
  localparam int BIT_CLOCK_OUTPUT_ENABLE    = 0;
  localparam int BIT_REGULATOR_POWER_DOWN   = 1;
  localparam int BIT_FULL_POWER_DOWN        = 2;
  localparam int BIT_WAKE_PIN_DIRECTION     = 3;
  localparam int BIT_WAKE_OUT_LEVEL         = 4;
  localparam int CTRL_USED_BITS             = 5;
  // control reset value: wake level high, everything else low
  localparam logic [4:0] CTRL_RESET         = 5'h10;
  // wake pulse minimum and the slow clock rate
  localparam real WAKE_PULSE_MIN_US         = 30.5;
  localparam real SLOW_CLK_HZ               = 32768.0;
  localparam real SYS_CLK_HZ                = 20000000.0;
  // system cycles per slow tick, rounded down to stay under the slow period
  localparam int  SLOW_TICK_CYCLES          = int'(SYS_CLK_HZ / SLOW_CLK_HZ - 0.5);
  // slow ticks needed for the regulator to settle in this model
  localparam int  REG_SETTLE_TICKS          = 4;
  // control fields travel together
  typedef struct packed {
    logic wakeOutLevel;
    logic wakePinDirection;
    logic fullPowerDown;
    logic regulatorPowerDown;
    logic clockOutputEnable;
  } ctrl_t;
  // power sequencer states
  typedef enum logic [1:0] {
    ST_ON,
    ST_DOWN,
    ST_RAMP
  } pwr_state_t;
endpackage : rtc_pwr_pkg

// >>> slow_tick_gen.sv
// divider that makes the one-cycle slow clock enable
`timescale 1ns/10ps
module slow_tick_gen #(
  parameter int DIV = rtc_pwr_pkg::SLOW_TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  output logic      tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_nxt;

  // refuse a divider too short to leave idle cycles between pulses
  if (DIV < 2)
  begin : g_bad_div
    $error("slow_tick_gen: DIV must be at least 2");
  end

  // count down and pulse once per slow period
  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r - CW'(1);
    if (cnt_r == '0)
    begin
      cnt_nxt  = CW'(DIV - 1);
      tick_nxt = 1'b1;
    end
  end

  // register the divider
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule : slow_tick_gen

// >>> rtc_power_wake_control.sv
// power and wake control: control register, wake pin, regulator sequencing, AHB-Lite slave
// Functional notes
// RQ1: external wake pulse must be high at least 30.5 us.
// RQ2: after wake, supply-good stays low until regulator output crosses threshold.
// RQ3: at threshold, raise supply-good, ending isolation and allowing register access.
// RQ4: wake level bit 4: 0 drives pin low, 1 releases pin.
// RQ5: wake direction bit 3: 0 makes pin input, 1 output.
// RQ6: input pin is active high; output only pulls low or releases.
// RQ7: pin wake works only while direction selects input.
// RQ8: full power-down bit 2 disables regulators, power-on reset and bandgap.
// RQ9: after full power-down, wake pin high or alarm re-enables everything.
// RQ10: regulator power-down bit 1 disables regulators and reset, keeps bandgap.
// RQ11: clock output enable bit 0 gates clock output pin.
// RQ12: bits 15:5 read zero and ignore writes.
// RQ13: reset sets wake level bit to 1, other bits to 0.
// RQ14: software uses power-down bits only when internal regulators supply chip.
// RQ15: setting either power-down bit shuts core regulator, supply-good low.
// RQ16: writes take effect after two slow-clock cycles.
// RQ17: wake pin sampled on slow ticks so one-period pulses are caught.
`timescale 1ns/10ps
module rtc_power_wake_control #(
  parameter int SETTLE_TICKS = rtc_pwr_pkg::REG_SETTLE_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        wakePinIn,
  output logic             wakePinOut,
  output logic             wakePinOe,
  input  wire logic        alarmIrq,
  input  wire logic        coreRegulatorOk,
  input  wire logic        slowClkIn,
  output logic             clkOut,
  output logic             regulatorEnable,
  output logic             porEnable,
  output logic             bandgapEnable,
  output logic             supplyGood,
  output logic             wakeEvent
);
  localparam int STW = $clog2(SETTLE_TICKS + 1);

  // a zero settle count would underflow the ramp compare
  if (SETTLE_TICKS < 1)
  begin : g_bad_settle
    $error("rtc_power_wake_control: SETTLE_TICKS must be at least 1");
  end

  // slow clock enable from the divider
  logic slowTick;
  slow_tick_gen #(
    .DIV (rtc_pwr_pkg::SLOW_TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (slowTick)
  );

  // pin synchronisers: first stage feeds only the second
  logic wakeMeta_r;
  logic wakeSync_r;
  logic alarmMeta_r;
  logic alarmSync_r;
  logic regOkMeta_r;
  logic regOkSync_r;
  logic slowMeta_r;
  logic slowSync_r;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wakeMeta_r  <= 1'b0;
      wakeSync_r  <= 1'b0;
      alarmMeta_r <= 1'b0;
      alarmSync_r <= 1'b0;
      regOkMeta_r <= 1'b0;
      regOkSync_r <= 1'b0;
      slowMeta_r  <= 1'b0;
      slowSync_r  <= 1'b0;
    end
    else
    begin
      wakeMeta_r  <= wakePinIn;
      wakeSync_r  <= wakeMeta_r;
      alarmMeta_r <= alarmIrq;
      alarmSync_r <= alarmMeta_r;
      regOkMeta_r <= coreRegulatorOk;
      regOkSync_r <= regOkMeta_r;
      slowMeta_r  <= slowClkIn;
      slowSync_r  <= slowMeta_r;
    end
  end

  // bus slave state: staged write, two-tick commit, live control
  rtc_pwr_pkg::ctrl_t ctrl_r;
  rtc_pwr_pkg::ctrl_t ctrl_nxt;
  rtc_pwr_pkg::ctrl_t staged_r;
  rtc_pwr_pkg::ctrl_t staged_nxt;
  logic [1:0]         pendTicks_r;
  logic [1:0]         pendTicks_nxt;
  logic               pend_r;
  logic               pend_nxt;
  logic               wrPhase_r;
  logic               wrPhase_nxt;
  logic [31:0]        addr_r;
  logic [31:0]        addr_nxt;
  logic [31:0]        hrdata_nxt;
  logic               accept;
  logic [31:0]        statusWord;
  logic [31:0]        ctrlWord;
  rtc_pwr_pkg::pwr_state_t state_r;
  rtc_pwr_pkg::pwr_state_t state_nxt;

  // a new transfer is taken when selected, non-idle and the bus is ready
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // RQ12 reserved bits read zero
  assign ctrlWord  = {27'h0000000, ctrl_r};
  // status: pending write, supply-good, sequencer state
  assign statusWord = {27'h0000000, supplyGood, pend_r, regOkSync_r, 2'(state_r)};

  // bus decode and write commit
  always_comb
  begin
    ctrl_nxt      = ctrl_r;
    staged_nxt    = staged_r;
    pendTicks_nxt = pendTicks_r;
    pend_nxt      = pend_r;
    wrPhase_nxt   = accept & hwrite;
    addr_nxt      = accept ? haddr : addr_r;
    hrdata_nxt    = hrdata;
    if (accept & ~hwrite)
    begin
      if (haddr == rtc_pwr_pkg::ADDR_POWER_WAKE_CONTROL)
      begin
        hrdata_nxt = ctrlWord;
      end
      else if (haddr == rtc_pwr_pkg::ADDR_STATUS)
      begin
        hrdata_nxt = statusWord;
      end
      else
      begin
        hrdata_nxt = 32'h0000_0000;
      end
    end
    // RQ12 upper bits of hwdata are dropped
    if (wrPhase_r && addr_r == rtc_pwr_pkg::ADDR_POWER_WAKE_CONTROL)
    begin
      staged_nxt    = rtc_pwr_pkg::ctrl_t'(hwdata[rtc_pwr_pkg::CTRL_USED_BITS-1:0]);
      pend_nxt      = 1'b1;
      pendTicks_nxt = 2'h0;
    end
    // RQ16 commit after two slow ticks
    else if (pend_r && slowTick)
    begin
      if (pendTicks_r == 2'h1)
      begin
        ctrl_nxt = staged_r;
        pend_nxt = 1'b0;
      end
      pendTicks_nxt = pendTicks_r + 2'h1;
    end
    // RQ9 hardware wake clears the power-down bits
    if (state_r == rtc_pwr_pkg::ST_DOWN && state_nxt == rtc_pwr_pkg::ST_RAMP)
    begin
      ctrl_nxt.fullPowerDown      = 1'b0;
      ctrl_nxt.regulatorPowerDown = 1'b0;
    end
  end

  // register the bus side
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // RQ13 reset values
      ctrl_r      <= rtc_pwr_pkg::ctrl_t'(rtc_pwr_pkg::CTRL_RESET);
      staged_r    <= rtc_pwr_pkg::ctrl_t'(rtc_pwr_pkg::CTRL_RESET);
      pendTicks_r <= 2'h0;
      pend_r      <= 1'b0;
      wrPhase_r   <= 1'b0;
      addr_r      <= 32'h0000_0000;
      hrdata      <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      staged_r    <= staged_nxt;
      pendTicks_r <= pendTicks_nxt;
      pend_r      <= pend_nxt;
      wrPhase_r   <= wrPhase_nxt;
      addr_r      <= addr_nxt;
      hrdata      <= hrdata_nxt;
    end
  end

  // power sequencer on slow ticks
  logic             wakeReq;
  logic [STW-1:0]   settle_r;
  logic [STW-1:0]   settle_nxt;
  logic             wakeEvent_nxt;
  // RQ7 pin wake only while the pin is an input
  // RQ6 input level is active high
  assign wakeReq = (wakeSync_r & ~ctrl_r.wakePinDirection) | alarmSync_r;

  always_comb
  begin
    state_nxt     = state_r;
    settle_nxt    = settle_r;
    wakeEvent_nxt = 1'b0;
    // RQ17 wake is sampled only on slow ticks
    if (slowTick)
    begin
      case (state_r)
        rtc_pwr_pkg::ST_ON:
        begin
          // RQ15 either power-down bit shuts the regulator
          if (ctrl_r.fullPowerDown | ctrl_r.regulatorPowerDown)
          begin
            state_nxt = rtc_pwr_pkg::ST_DOWN;
          end
        end
        rtc_pwr_pkg::ST_DOWN:
        begin
          // RQ9 wake or alarm restarts supplies
          if (wakeReq)
          begin
            state_nxt     = rtc_pwr_pkg::ST_RAMP;
            settle_nxt    = '0;
            wakeEvent_nxt = 1'b1;
          end
        end
        rtc_pwr_pkg::ST_RAMP:
        begin
          // RQ2 hold until the regulator crosses its threshold
          if (regOkSync_r && settle_r >= STW'(SETTLE_TICKS - 1))
          begin
            state_nxt = rtc_pwr_pkg::ST_ON;
          end
          else if (settle_r < STW'(SETTLE_TICKS - 1))
          begin
            settle_nxt = settle_r + STW'(1);
          end
        end
        default:
        begin
          state_nxt = rtc_pwr_pkg::ST_ON;
        end
      endcase
    end
  end

  // register the sequencer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r   <= rtc_pwr_pkg::ST_ON;
      settle_r  <= '0;
      wakeEvent <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      settle_r  <= settle_nxt;
      wakeEvent <= wakeEvent_nxt;
    end
  end

  // supply enables and supply-good, registered so pins never glitch
  logic regEn_nxt;
  logic bgEn_nxt;
  logic good_nxt;
  logic clkOut_nxt;
  always_comb
  begin
    // RQ8 full power-down kills bandgap too
    // RQ10 regulator power-down keeps the bandgap
    regEn_nxt  = (state_r != rtc_pwr_pkg::ST_DOWN);
    bgEn_nxt   = ~((state_r == rtc_pwr_pkg::ST_DOWN) & ctrl_r.fullPowerDown);
    // RQ3 supply-good only once powered up and regulator valid
    good_nxt   = (state_r == rtc_pwr_pkg::ST_ON) & regOkSync_r;
    // RQ11 clock output gated by its enable
    clkOut_nxt = slowSync_r & ctrl_r.clockOutputEnable;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      regulatorEnable <= 1'b1;
      porEnable       <= 1'b1;
      bandgapEnable   <= 1'b1;
      supplyGood      <= 1'b0;
      clkOut          <= 1'b0;
    end
    else
    begin
      regulatorEnable <= regEn_nxt;
      porEnable       <= regEn_nxt;
      bandgapEnable   <= bgEn_nxt;
      supplyGood      <= good_nxt;
      clkOut          <= clkOut_nxt;
    end
  end

  // RQ4 open drain: drive low only, release for a one
  // RQ5 output only when direction is set
  assign wakePinOut = 1'b0;
  assign wakePinOe  = ctrl_r.wakePinDirection & ~ctrl_r.wakeOutLevel;
endmodule : rtc_power_wake_control

// >>> rtc_power_wake_control_properties.sv
// checker: port-level properties of the power and wake control block
`timescale 1ns/10ps
module rtc_power_wake_control_properties (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        wakePinOut,
  input wire logic        wakePinOe,
  input wire logic        coreRegulatorOk,
  input wire logic        regulatorEnable,
  input wire logic        porEnable,
  input wire logic        bandgapEnable,
  input wire logic        supplyGood,
  input wire logic        wakeEvent
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // open drain: the pin is only ever pulled low
  property p_pull_low; wakePinOe |-> !wakePinOut; endproperty
  a_pull_low: assert property (p_pull_low) else $error("wake pin driven high");
  property p_por_reg; porEnable == regulatorEnable; endproperty
  a_por_reg: assert property (p_por_reg) else $error("reset and regulator split");
  property p_bg_full; !bandgapEnable |-> !regulatorEnable && !porEnable; endproperty
  a_bg_full: assert property (p_bg_full) else $error("bandgap off alone");
  property p_iso_down; !regulatorEnable [*2] |-> !supplyGood; endproperty
  a_iso_down: assert property (p_iso_down) else $error("supply good while off");
  property p_iso_ramp; !coreRegulatorOk [*4] |-> !supplyGood; endproperty
  a_iso_ramp: assert property (p_iso_ramp) else $error("supply good below threshold");
  // three cycles of sync and register before supply good may rise
  property p_good_on; $rose(supplyGood) |-> regulatorEnable && $past(coreRegulatorOk, 3); endproperty
  a_good_on: assert property (p_good_on) else $error("supply good without regulator");
  property p_wake_once; wakeEvent |=> !wakeEvent; endproperty
  a_wake_once: assert property (p_wake_once) else $error("wake event too long");
  property p_wake_up; wakeEvent |-> ##[0:2] regulatorEnable && bandgapEnable; endproperty
  a_wake_up: assert property (p_wake_up) else $error("wake did not enable supplies");
  property p_rsv_zero; $past(hsel && htrans[1] && hready && !hwrite && haddr == rtc_pwr_pkg::ADDR_POWER_WAKE_CONTROL)
    |-> hrdata[31:5] == 27'h0; endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
endmodule : rtc_power_wake_control_properties

bind rtc_power_wake_control rtc_power_wake_control_properties i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .wakePinOut(wakePinOut), .wakePinOe(wakePinOe), .coreRegulatorOk(coreRegulatorOk),
  .regulatorEnable(regulatorEnable), .porEnable(porEnable), .bandgapEnable(bandgapEnable),
  .supplyGood(supplyGood), .wakeEvent(wakeEvent));

// >>> ext_power_model.sv
// partner: crystal clock, core regulator ramp and external wake driver
`timescale 1ns/10ps
module ext_power_model #(
  parameter int RAMP = 300
) (
  input  wire logic clk_sys,
  input  wire logic regulatorEnable,
  input  wire logic wakeReq,
  output logic      slowClkIn,
  output logic      coreRegulatorOk,
  output logic      wakeDrive
);
  int slowCnt = 0;
  int rampCnt = 0;
  int pulseCnt = 0;
  initial
  begin
    slowClkIn = 1'b0;
    coreRegulatorOk = 1'b0;
    wakeDrive = 1'b0;
  end
  // crystal runs free; regulator output only crosses threshold after a ramp
  always @(posedge clk_sys)
  begin
    slowCnt <= (slowCnt == 304) ? 0 : slowCnt + 1;
    if (slowCnt == 304)
      slowClkIn <= ~slowClkIn;
    rampCnt <= regulatorEnable ? ((rampCnt < RAMP) ? rampCnt + 1 : rampCnt) : 0;
    coreRegulatorOk <= regulatorEnable && rampCnt >= RAMP;
    // wake pulse width: well over one slow period
    pulseCnt <= (wakeReq && pulseCnt == 0) ? 1300 : (pulseCnt > 0 ? pulseCnt - 1 : 0);
    wakeDrive <= pulseCnt > 1;
  end
endmodule : ext_power_model

// >>> testbench.sv
// testbench: bus-level tests of the power and wake control block
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] CTRL = rtc_pwr_pkg::ADDR_POWER_WAKE_CONTROL;
  logic        clk_sys, sys_rst, hsel, hwrite, hreadyout, hresp, wakePinOut, wakePinOe;
  logic        alarmIrq, coreRegulatorOk, slowClkIn, clkOut, regulatorEnable, porEnable;
  logic        bandgapEnable, supplyGood, wakeEvent, wakeReq, wakeDrive, seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  int          badCount, comparisons, cycles, n;
  rtc_power_wake_control #(.SETTLE_TICKS(2)) i_rtc_power_wake_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wakePinIn(wakePinOe ? 1'b0 : wakeDrive), .wakePinOut(wakePinOut), .wakePinOe(wakePinOe),
    .alarmIrq(alarmIrq), .coreRegulatorOk(coreRegulatorOk), .slowClkIn(slowClkIn), .clkOut(clkOut),
    .regulatorEnable(regulatorEnable), .porEnable(porEnable), .bandgapEnable(bandgapEnable),
    .supplyGood(supplyGood), .wakeEvent(wakeEvent));
  ext_power_model i_ext_power_model (.clk_sys(clk_sys), .regulatorEnable(regulatorEnable),
    .wakeReq(wakeReq), .slowClkIn(slowClkIn), .coreRegulatorOk(coreRegulatorOk), .wakeDrive(wakeDrive));
  // one AHB-Lite single word transfer; waits are bounded by the timeout
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // poll the pending flag; a write lands only after two slow ticks
  task automatic wait_commit;
    n = 0;
    do
    begin
      bus(1'b0, rtc_pwr_pkg::ADDR_STATUS, 32'h0, rd);
      n++;
    end
    while (rd[3] !== 1'b0 && n < 800);
    // a write that never lands counts as a mismatch
    if (rd[3] !== 1'b0)
    begin
      badCount++;
      $display("wrong value write pending expected 0 seen %b", rd[3]);
    end
  endtask : wait_commit
  task automatic wait_until(input int sel, input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk_sys);
      if (sel == 0 ? regulatorEnable === 1'b0 : sel == 1 ? wakeEvent === 1'b1 : supplyGood === 1'b1)
      begin
        hit = 1'b1;
        break;
      end
    end
    // an event that never comes counts as a mismatch
    if (!hit)
    begin
      badCount++;
      $display("wrong value wait %0d expected event seen none", sel);
    end
  endtask : wait_until
  // power down, wake by pin or alarm, check supplies come back
  task automatic power_cycle(input logic [31:0] val, input logic useAlarm, input logic bgExp);
    // power-down used only with internal regulators supplying
    bus(1'b1, CTRL, val, rd);
    wait_commit;
    wait_until(0, 1300);
    check("regulator enable", 32'h0, {31'h0, regulatorEnable});
    check("reset enable off", 32'h0, {31'h0, porEnable});
    check("supply good down", 32'h0, {31'h0, supplyGood});
    check("bandgap enable", {31'h0, bgExp}, {31'h0, bandgapEnable});
    @(posedge clk_sys);
    wakeReq <= 1'b1;
    @(posedge clk_sys);
    wakeReq <= 1'b0;
    if (useAlarm)
    begin
      repeat (2600) @(negedge clk_sys);
      check("pin ignored as output", 32'h0, {31'h0, regulatorEnable});
      @(posedge clk_sys);
      alarmIrq <= 1'b1;
    end
    wait_until(1, 2600);
    check("wake event", 32'h1, {31'h0, wakeEvent});
    @(posedge clk_sys);
    alarmIrq <= 1'b0;
    wait_until(2, 5000);
    check("supply good up", 32'h1, {31'h0, supplyGood});
    check("bandgap back", 32'h1, {31'h0, bandgapEnable});
    bus(1'b0, CTRL, 32'h0, rd);
    check("power bits cleared", val & 32'h18, rd);
  endtask : power_cycle
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard: the whole run needs about 13000 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      badCount++;
      print_verdict;
    end
  end
  initial
  begin
    sys_rst     = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    alarmIrq    = 1'b0;
    wakeReq     = 1'b0;
    badCount    = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1'b0, CTRL, 32'h0, rd);
    check("reset control", {27'h0, rtc_pwr_pkg::CTRL_RESET}, rd);
    bus(1'b0, 32'h0000_1938, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    check("bus response okay", 32'h0, {31'h0, hresp});
    bus(1'b1, CTRL, 32'hFFFF_FFE9, rd);
    bus(1'b0, CTRL, 32'h0, rd);
    check("control before commit", {27'h0, rtc_pwr_pkg::CTRL_RESET}, rd);
    wait_commit;
    bus(1'b0, CTRL, 32'h0, rd);
    check("reserved bits", 32'h09, rd);
    check("pin pulled low", 32'h1, {31'h0, wakePinOe});
    wait_until(3, 700);
    seen = 1'b0;
    repeat (700) @(negedge clk_sys) seen |= (clkOut === 1'b1);
    check("clock out running", 32'h1, {31'h0, seen});
    bus(1'b1, CTRL, 32'h10, rd);
    wait_commit;
    check("pin released", 32'h0, {31'h0, wakePinOe});
    seen = 1'b0;
    repeat (700) @(negedge clk_sys) seen |= (clkOut !== 1'b0);
    check("clock out stopped", 32'h0, {31'h0, seen});
    power_cycle(32'h12, 1'b0, 1'b1);
    power_cycle(32'h1C, 1'b1, 1'b0);
    print_verdict;
  end
endmodule : testbench
